/* inc/frabo_defs.svh */
// ----------------------------------------------------------------------
// frabo_defs.svh
// ----------------------------------------------------------------------
// offsets of instruction fields, opcode values, reset values
// assumes a 14-bit instruction word, 8-bit data, 128 file registers
`ifndef FRABO_DEFS_SVH
`define FRABO_DEFS_SVH

// instruction field positions
`define FRABO_MAJ_HI     13
`define FRABO_MAJ_LO     8
`define FRABO_BOP_HI     13
`define FRABO_BOP_LO     10
`define FRABO_DEST_BIT   7
`define FRABO_ADDR_HI    6
`define FRABO_ADDR_LO    0
`define FRABO_BSEL_HI    9
`define FRABO_BSEL_LO    7

// opcode values
`define FRABO_OPC_ADD    6'h07
`define FRABO_OPC_AND    6'h05
`define FRABO_OPC_BCLR   4'h4
`define FRABO_OPC_BTSZ   4'h6

// reset values
`define FRABO_ACC_RST    8'h00
`define FRABO_FLAG_RST   1'b0

// sizes
`define FRABO_FILE_DEPTH 128

`endif

/* inc/frabo_pkg.sv */
// ----------------------------------------------------------------------
// frabo_pkg: types of the file-register execute stage
// ----------------------------------------------------------------------
// assumes nothing beyond a SystemVerilog compiler
package frabo_pkg;

   typedef enum logic [2:0] {
      op_none,
      op_add,
      op_and,
      op_bclr,
      op_btest
   } frabo_op_t;

   typedef enum logic {
      st_run,
      st_idle
   } frabo_state_t;

endpackage

/* inc/frabo_alu_if.sv */
// ----------------------------------------------------------------------
// frabo_alu_if: operands and results between core and its alu
// ----------------------------------------------------------------------
// assumes the alu is purely combinational
interface frabo_alu_if;
   import frabo_pkg::*;

   frabo_op_t  op;
   logic [7:0] acc_in;
   logic [7:0] file_in;
   logic [2:0] bit_sel;
   logic [7:0] result;
   logic       carry_out;
   logic       nibble_out;
   logic       zero_out;
   logic       bit_val;

   modport core (
      output op,
      output acc_in,
      output file_in,
      output bit_sel,
      input  result,
      input  carry_out,
      input  nibble_out,
      input  zero_out,
      input  bit_val
   );

   modport alu (
      input  op,
      input  acc_in,
      input  file_in,
      input  bit_sel,
      output result,
      output carry_out,
      output nibble_out,
      output zero_out,
      output bit_val
   );

endinterface

/* rtl/frabo_alu.sv */
// ----------------------------------------------------------------------
// frabo_alu: add, and, bit clear and bit test on 8-bit operands
// ----------------------------------------------------------------------
// assumes operands are stable for the whole cycle; no state inside
module frabo_alu (
   frabo_alu_if.alu a
);
   import frabo_pkg::*;

   logic [4:0] low_sum;
   logic [8:0] full_sum;
   logic [7:0] mask;

   always_comb begin
      low_sum  = {1'b0, a.acc_in[3:0]} + {1'b0, a.file_in[3:0]};
      full_sum = {1'b0, a.acc_in} + {1'b0, a.file_in};
      mask     = 8'h01 << a.bit_sel;
      a.carry_out  = full_sum[8];
      a.nibble_out = low_sum[4];
      a.bit_val    = |(a.file_in & mask);
      case (a.op)
         op_add:  a.result = full_sum[7:0];
         op_and:  a.result = a.acc_in & a.file_in;
         op_bclr: a.result = a.file_in & ~mask;
         default: a.result = a.file_in;
      endcase
      a.zero_out = (a.result == 8'h00);
   end

endmodule // frabo_alu

/* rtl/frabo_top.sv */
// ----------------------------------------------------------------------
// frabo_top: execute stage for add, and, bit clear, bit test and skip
// ----------------------------------------------------------------------
// assumes a fetched instruction arrives each cycle on core_clk from
// logic in the same clock domain; other instructions are ignored here
//
// Functional notes
// - Opcode 00 0111 adds acc and file reg, updating carry, nibble, zero.
// - For add and and, dest bit 0 writes acc and 1 writes the file reg.
// - Opcode 00 0101 ands acc with file reg and changes only the zero flag.
// - Opcode 01 00bb clears bit b of the file reg with no flag change.
// - Opcode 01 10bb tests bit b and skips the next word when it is zero.
// - A taken skip drops the fetched next word and runs an idle cycle.
`include "frabo_defs.svh"

module frabo_top (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [13:0] instr,
   input  wire logic        instr_valid,
   input  wire logic        ext_wr_en,
   input  wire logic [6:0]  ext_wr_addr,
   input  wire logic [7:0]  ext_wr_data,
   input  wire logic [6:0]  dbg_addr,
   output logic      [7:0]  dbg_data,
   output logic      [7:0]  acc,
   output logic             carry_flag,
   output logic             nibble_carry_flag,
   output logic             zero_flag,
   output logic             idle_cycle,
   output logic             skip_taken,
   output logic             exec_done
);
   import frabo_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]   file_mem [`FRABO_FILE_DEPTH];
   frabo_state_t state;
   frabo_state_t next_state;
   logic [7:0]   next_acc;
   logic         next_carry_flag;
   logic         next_nibble_carry_flag;
   logic         next_zero_flag;
   logic         next_skip_taken;
   logic         next_exec_done;
   logic         next_wr_en;
   logic [6:0]   next_wr_addr;
   logic [7:0]   next_wr_data;
   logic [7:0]   next_dbg_data;

   frabo_op_t    op;
   logic [6:0]   f_addr;
   logic         dest_file;
   logic         to_acc;
   logic         to_file;

   frabo_alu_if  alu_bus ();

   frabo_alu u_alu (
      .a (alu_bus.alu)
   );

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // in the idle slot the fetched word is dropped, whatever it holds
   always_comb begin
      f_addr    = instr[`FRABO_ADDR_HI:`FRABO_ADDR_LO];
      dest_file = instr[`FRABO_DEST_BIT];
      op        = op_none;
      if (instr_valid && state == st_run) begin
         if (instr[`FRABO_MAJ_HI:`FRABO_MAJ_LO] == `FRABO_OPC_ADD) begin
            op = op_add;
         end else if (instr[`FRABO_MAJ_HI:`FRABO_MAJ_LO]
                      == `FRABO_OPC_AND) begin
            op = op_and;
         end else if (instr[`FRABO_BOP_HI:`FRABO_BOP_LO]
                      == `FRABO_OPC_BCLR) begin
            op = op_bclr;
         end else if (instr[`FRABO_BOP_HI:`FRABO_BOP_LO]
                      == `FRABO_OPC_BTSZ) begin
            op = op_btest;
         end
      end
   end

   assign alu_bus.op      = op;
   assign alu_bus.acc_in  = acc;
   assign alu_bus.file_in = file_mem[f_addr];
   assign alu_bus.bit_sel = instr[`FRABO_BSEL_HI:`FRABO_BSEL_LO];

   // ----------------------------------------------------------------
   // write-back routing
   // ----------------------------------------------------------------
   // add and and pick their target by the destination bit; bit clear
   // always lands in the file register it read
   always_comb begin
      to_acc  = 1'b0;
      to_file = 1'b0;
      case (op)
         op_add, op_and: begin
            to_acc  = !dest_file;
            to_file = dest_file;
         end
         op_bclr: begin
            to_file = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // ----------------------------------------------------------------
   // sequencer: skip slot and completion pulses
   // ----------------------------------------------------------------
   // a skip costs one whole cycle; the word fetched meanwhile is dropped
   // exec_done counts only real work, never ignored words or idle slots
   always_comb begin
      next_state      = st_run;
      next_skip_taken = 1'b0;
      next_exec_done  = (op != op_none);
      if (op == op_btest && !alu_bus.bit_val) begin
         next_state      = st_idle;
         next_skip_taken = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state      <= st_run;
         skip_taken <= 1'b0;
         exec_done  <= 1'b0;
      end else begin
         state      <= next_state;
         skip_taken <= next_skip_taken;
         exec_done  <= next_exec_done;
      end
   end

   // ----------------------------------------------------------------
   // accumulator and status flags
   // ----------------------------------------------------------------
   // and must leave carry and nibble carry alone: code that tests them
   // after an and still relies on the earlier add
   always_comb begin
      next_acc               = acc;
      next_carry_flag        = carry_flag;
      next_nibble_carry_flag = nibble_carry_flag;
      next_zero_flag         = zero_flag;
      case (op)
         op_add: begin
            next_carry_flag        = alu_bus.carry_out;
            next_nibble_carry_flag = alu_bus.nibble_out;
            next_zero_flag         = alu_bus.zero_out;
         end
         op_and: begin
            next_zero_flag = alu_bus.zero_out;
         end
         default: begin
         end
      endcase
      if (to_acc) begin
         next_acc = alu_bus.result;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         acc               <= `FRABO_ACC_RST;
         carry_flag        <= `FRABO_FLAG_RST;
         nibble_carry_flag <= `FRABO_FLAG_RST;
         zero_flag         <= `FRABO_FLAG_RST;
      end else begin
         acc               <= next_acc;
         carry_flag        <= next_carry_flag;
         nibble_carry_flag <= next_nibble_carry_flag;
         zero_flag         <= next_zero_flag;
      end
   end

   // ----------------------------------------------------------------
   // file array write port
   // ----------------------------------------------------------------
   // the instruction's write-back beats an external write
   always_comb begin
      next_wr_en   = ext_wr_en;
      next_wr_addr = ext_wr_addr;
      next_wr_data = ext_wr_data;
      if (to_file) begin
         next_wr_en   = 1'b1;
         next_wr_addr = f_addr;
         next_wr_data = alu_bus.result;
      end
   end

   // no reset on the array: contents are undefined until written
   always_ff @(posedge core_clk) begin
      if (next_wr_en) begin
         file_mem[next_wr_addr] <= next_wr_data;
      end
   end

   // ----------------------------------------------------------------
   // observation port
   // ----------------------------------------------------------------
   // registered so the read path adds nothing to the write-back timing
   always_comb begin
      next_dbg_data = file_mem[dbg_addr];
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dbg_data <= 8'h00;
      end else begin
         dbg_data <= next_dbg_data;
      end
   end

   assign idle_cycle = (state == st_idle);

endmodule // frabo_top

/* sim/frabo_props.sv */
// checker for the file-register execute stage
// assumes it sees only the ports of frabo_top, one clock domain
module frabo_props (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [13:0] instr,
   input wire logic        instr_valid,
   input wire logic [7:0]  acc,
   input wire logic        carry_flag,
   input wire logic        nibble_carry_flag,
   input wire logic        zero_flag,
   input wire logic        idle_cycle,
   input wire logic        skip_taken,
   input wire logic        exec_done
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // decode of what is taken
   // ----
   logic take;
   logic add_op;
   logic and_op;
   logic bit_op;
   // words in the idle slot are dropped, so they never count
   assign take = instr_valid && !idle_cycle;
   assign add_op = take && instr[13:8] == 6'h07;
   assign and_op = take && instr[13:8] == 6'h05;
   assign bit_op = take && instr[13:12] == 2'b01 && !instr[10];

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   add_done_a: assert property (add_op |=> exec_done)
      else $error("add did not complete");
   dest_file_a: assert property ((add_op || and_op) && instr[7]
      |=> $stable(acc)) else $error("acc written for file dest");
   and_flags_a: assert property (and_op
      |=> $stable(carry_flag) && $stable(nibble_carry_flag))
      else $error("and changed carry flags");
   zero_acc_a: assert property ((add_op || and_op) && !instr[7]
      |=> zero_flag == (acc == 8'h00)) else $error("zero flag wrong");
   bit_flags_a: assert property (bit_op
      |=> $stable({carry_flag, nibble_carry_flag, zero_flag, acc}))
      else $error("bit op changed flags or acc");
   skip_cause_a: assert property (skip_taken
      |-> $past(instr_valid) && $past(instr[13:10]) == 4'h6)
      else $error("skip without bit test");
   idle_slot_a: assert property (idle_cycle
      |-> skip_taken && exec_done ##1 !idle_cycle && !exec_done)
      else $error("idle slot wrong");

   cover property (skip_taken);
   cover property (and_op && instr[7]);
   cover property (add_op ##1 carry_flag && nibble_carry_flag && zero_flag);
endmodule // frabo_props

bind frabo_top frabo_props u_props (.core_clk, .rst, .instr, .instr_valid,
   .acc, .carry_flag, .nibble_carry_flag, .zero_flag, .idle_cycle,
   .skip_taken, .exec_done);

/* sim/tb_top.sv */
// self-checking bench for frabo_top
// assumes the file array is loaded through the external write port
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ----
   // stimulus and rows
   // ----
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [13:0] instr = 14'h0000;
   logic        instr_valid = 1'b0;
   logic        ext_wr_en = 1'b0;
   logic [6:0]  ext_wr_addr = 7'h00;
   logic [7:0]  ext_wr_data = 8'h00;
   logic [6:0]  dbg_addr = 7'h00;
   logic [7:0]  dbg_data;
   logic [7:0]  acc;
   logic        carry_flag;
   logic        nibble_carry_flag;
   logic        zero_flag;
   logic        idle_cycle;
   logic        skip_taken;
   logic        exec_done;
   logic [7:0]  flg_seen;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc = 0;
   // flags packed as carry, nibble carry, zero
   typedef struct packed {
      logic [13:0] ins;
      logic [7:0]  acc;
      logic [2:0]  flg;
      logic [7:0]  file;
      logic        ex;
   } frabo_row_t;
   frabo_row_t rows[13] = '{
      '{14'h0710, 8'hC2, 3'h0, 8'hC2, 1'b1},
      '{14'h0791, 8'hC2, 3'h0, 8'hD9, 1'b1},
      '{14'h0710, 8'h84, 3'h4, 8'hC2, 1'b1},
      '{14'h0514, 8'h00, 3'h5, 8'h01, 1'b1},
      '{14'h0713, 8'h0F, 3'h0, 8'h0F, 1'b1},
      '{14'h0713, 8'h1E, 3'h2, 8'h0F, 1'b1},
      '{14'h0591, 8'h1E, 3'h2, 8'h18, 1'b1},
      '{14'h0594, 8'h1E, 3'h3, 8'h00, 1'b1},
      '{14'h0715, 8'h00, 3'h7, 8'hE2, 1'b1},
      '{14'h1392, 8'h00, 3'h7, 8'h47, 1'b1},
      '{14'h1012, 8'h00, 3'h7, 8'h46, 1'b1},
      '{14'h1B12, 8'h00, 3'h7, 8'h46, 1'b1},
      '{14'h3F12, 8'h00, 3'h7, 8'h46, 1'b0}};

   frabo_top uut (.core_clk, .rst, .instr, .instr_valid, .ext_wr_en,
      .ext_wr_addr, .ext_wr_data, .dbg_addr, .dbg_data, .acc, .carry_flag,
      .nibble_carry_flag, .zero_flag, .idle_cycle, .skip_taken, .exec_done);

   assign flg_seen = {5'h00, carry_flag, nibble_carry_flag, zero_flag};

   always #50 core_clk = ~core_clk;

   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [6:0] a, logic [7:0] d);
      @(negedge core_clk);
      ext_wr_en = 1'b1;
      ext_wr_addr = a;
      ext_wr_data = d;
   endtask
   task automatic issue(logic [13:0] w);
      @(negedge core_clk);
      instr = w;
      instr_valid = 1'b1;
      dbg_addr = w[6:0];
      @(negedge core_clk);
   endtask
   task automatic summarize();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // generous: the whole sequence needs well under 100 cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      wr(7'h10, 8'hC2);
      wr(7'h11, 8'h17);
      wr(7'h12, 8'hC7);
      wr(7'h13, 8'h0F);
      wr(7'h14, 8'h01);
      wr(7'h15, 8'hE2);
      @(negedge core_clk);
      ext_wr_en = 1'b0;
      foreach (rows[i]) begin
         issue(rows[i].ins);
         chk("acc", rows[i].acc, acc);
         chk("flags", {5'h00, rows[i].flg}, flg_seen);
         chk("exec_done", {7'h00, rows[i].ex}, {7'h00, exec_done});
         chk("skip", 8'h00, {6'h00, skip_taken, idle_cycle});
         instr_valid = 1'b0;
         @(negedge core_clk);
         chk("file", rows[i].file, dbg_data);
      end
      issue(14'h1812);
      instr = 14'h0710;
      chk("skip", 8'h03, {6'h00, skip_taken, idle_cycle});
      chk("exec_done", 8'h01, {7'h00, exec_done});
      @(negedge core_clk);
      chk("acc_kept", 8'h00, acc);
      chk("idle_end", 8'h00, {6'h00, idle_cycle, exec_done});
      @(negedge core_clk);
      chk("acc_after", 8'hC2, acc);
      // one more add so that reset has set flags to clear
      @(negedge core_clk);
      instr_valid = 1'b0;
      chk("acc_pre", 8'h84, acc);
      chk("flags_pre", 8'h04, flg_seen);
      rst = 1'b1;
      @(negedge core_clk);
      chk("acc_rst", 8'h00, acc);
      chk("flags_rst", 8'h00, flg_seen);
      summarize();
   end
endmodule // tb_top
